// ==== bench/txbic_bp_model.sv ====
// Behavioural backplane logic that feeds the transmit pin control.
`timescale 1ns/1ps
`default_nettype none

module txbic_bp_model (
  // Frame length in link bits for the current speed and multiplex setting
  input wire logic [10:0] frame_bits_i,
  // Backplane transmit clock, frame sync and serial data
  output logic link_clk_o,
  output logic frame_sync_o,
  output logic ser_o,
  // Identifier pin wires
  input wire logic sig_val_i,
  input wire logic frac_val_i,
  input wire logic [4:0] pin_dev_i,
  input wire logic [4:0] pin_oe_i,
  output logic [4:0] pin_o
);
  logic [10:0] pos_r = 11'h000;

  initial begin
    link_clk_o = 1'b0;
    #13;
    forever #40 link_clk_o = ~link_clk_o;
  end

  // Launch on the falling edge so the device sees half a cycle of setup.
  always @(negedge link_clk_o) begin
    pos_r <= (pos_r >= frame_bits_i - 11'h001) ? 11'h000 : pos_r + 11'h001;
  end

  assign frame_sync_o = (pos_r == 11'h000);
  assign ser_o = pos_r[0] ^ pos_r[2];
  assign pin_o[0] = pin_oe_i[0] ? pin_dev_i[0] : sig_val_i;
  assign pin_o[1] = pin_oe_i[1] ? pin_dev_i[1] : frac_val_i;
  // A pin nobody drives shows the inverse of its last output, never a stale copy.
  assign pin_o[4:2] = pin_dev_i[4:2] ~^ pin_oe_i[4:2];
endmodule

`default_nettype wire

// ==== bench/txbic_tb_top.sv ====
// Self-checking testbench for the transmit backplane pin control.
`timescale 1ns/1ps
`default_nettype none
`include "txbic_defs.svh"

module txbic_tb_top
  import txbic_pkg::*;
;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic fclk = 1'b0;
  txbic_req_s req_i = '0;
  logic [7:0] rdata_o;
  logic lclk;
  logic fsync;
  logic ser;
  logic sig_v = 1'b0;
  logic frac_v = 1'b0;
  logic [10:0] frame_bits = 11'h0C1;
  logic [4:0] pins_i;
  logic [4:0] pins_o;
  logic [4:0] pins_oe;
  txbic_line_s line_o;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int v0 = 0;
  int v1 = 0;
  int ovh = 0;
  logic p3_d = 1'b0;
  logic lvl = 1'b0;
  logic [4:0] maxslot = 5'h00;

  initial begin
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    forever #15.625 fclk = ~fclk;
  end

  txbic_top #(.MF_LAST(5'h02)) uut (
    .clock_i(clock_i), .reset_i(reset_i), .req_i(req_i), .rdata_o(rdata_o),
    .tx_link_clk_i(lclk), .tx_frame_sync_i(fsync), .tx_ser_i(ser), .fast_clk_32m_i(fclk),
    .timeslot_id_pins_i(pins_i), .timeslot_id_pins_o(pins_o),
    .timeslot_id_pins_oe_o(pins_oe), .line_o(line_o)
  );

  txbic_bp_model bp (
    .frame_bits_i(frame_bits), .link_clk_o(lclk), .frame_sync_o(fsync), .ser_o(ser),
    .sig_val_i(sig_v), .frac_val_i(frac_v), .pin_dev_i(pins_o), .pin_oe_i(pins_oe),
    .pin_o(pins_i)
  );

  always @(posedge lclk) begin
    if (line_o.valid0) v0++;
    if (line_o.valid1) v1++;
  end
  // The clock level at each data change tells which edge launched it.
  always @(pins_o[0]) lvl = lclk;
  always @(posedge clock_i) begin
    p3_d <= pins_o[3];
    if (pins_o[3] && !p3_d && pins_oe[3]) ovh++;
    if (pins_oe == 5'h1F && pins_o > maxslot) maxslot <= pins_o;
    cyc++;
    if (cyc == 70000) begin
      fails++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    req_i <= '0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock_i);
    req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    req_i <= '0;
    @(negedge clock_i);
    d = rdata_o;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e,
                      input string what);
    logic [7:0] d;
    rd(a, d);
    chk(d & m, e, what);
  endtask

  function automatic logic [10:0] fbits(input logic [7:0] v);
    if (v[2]) return (v[1:0] == 2'h0) ? 11'h301 : 11'h400;
    case (v[1:0])
      2'h0: return 11'h0C1;
      2'h1: return 11'h100;
      2'h2: return 11'h200;
      default: return 11'h400;
    endcase
  endfunction

  // Settings are quasi-static, so each change is given ten link cycles to land.
  task automatic cfg(input logic [7:0] v);
    wr(`TXBIC_CTRL_OFS, v);
    frame_bits <= fbits(v);
    repeat (80) @(posedge clock_i);
  endtask

  task automatic watch(input int n);
    @(negedge lclk);
    v0 = 0;
    v1 = 0;
    ovh = 0;
    maxslot = 5'h00;
    repeat (n) @(posedge lclk);
  endtask

  initial begin
    logic [7:0] m0;
    logic [7:0] m1;
    repeat (40) @(posedge clock_i);
    reset_i <= 1'b0;
    rchk(`TXBIC_CTRL_OFS, 8'hFF, `TXBIC_CTRL_RST, "ctrl reset");
    chk({3'h0, pins_oe}, 8'h1F, "oe reset");
    wr(`TXBIC_CTRL_OFS, 8'hFF);
    rchk(`TXBIC_CTRL_OFS, 8'hFF, `TXBIC_CTRL_WMASK, "reserved bit");
    wr(4'hC, 8'h5A);
    rchk(4'hC, 8'hFF, 8'h00, "unmapped");
    $display("test registers done");
    cfg(8'h00);
    watch(193);
    chk({3'h0, pins_oe}, 8'h1F, "oe base");
    chk({3'h0, maxslot}, 8'h17, "last slot");
    chk({7'h0, lvl}, 8'h01, "rise launch");
    chk(8'(v1), 8'h00, "no ch1");
    rchk(`TXBIC_STAT_OFS, 8'hE0, 8'h20, "base stat");
    $display("test base done");
    cfg(8'h10);
    for (int i = 0; i < 2; i++) begin
      @(posedge clock_i);
      sig_v <= (i == 0);
      frac_v <= (i != 0);
      // Start just after an overhead pulse so exactly one multiframe start lands in the window.
      @(posedge pins_o[3]);
      repeat (4) @(posedge clock_i);
      rd(`TXBIC_MFCNT_OFS, m0);
      watch(579);
      rd(`TXBIC_MFCNT_OFS, m1);
      chk(m1 - m0, 8'h01, "mf count");
      chk(8'(ovh), 8'h01, "ovh pulses");
      chk({3'h0, pins_oe}, 8'h1C, "oe alt");
      rchk(`TXBIC_STAT_OFS, 8'hF8, (i == 0) ? 8'hA8 : 8'hB0, "alt stat");
    end
    repeat (6) begin
      @(negedge clock_i);
      #1;
      chk({7'h0, pins_o[2]}, {7'h0, fclk}, "clk pin");
    end
    cfg(8'h00);
    chk({3'h0, pins_oe}, 8'h1F, "oe cleared");
    $display("test alternate roles done");
    cfg(8'h08);
    watch(193);
    chk({7'h0, lvl}, 8'h00, "fall launch");
    rchk(`TXBIC_STAT_OFS, 8'hE0, 8'h60, "inv stat");
    $display("test invert done");
    for (int s = 1; s < 6; s++) begin
      cfg((s < 4) ? (8'h18 | 8'(s)) : (8'h1C | 8'(s - 4)));
      watch(int'(frame_bits));
      chk({3'h0, pins_oe}, 8'h1E, "oe fast");
      chk({7'h0, lvl}, 8'h01, "inv ignored");
      rchk(`TXBIC_STAT_OFS, 8'hE0, 8'h00, "fast stat");
      chk(8'(v1 > 0), 8'(s > 3), "ch1 use");
      if (s > 3) chk(8'(v0 > v1 + 1 || v1 > v0 + 1), 8'h00, "ch balance");
    end
    $display("test speeds and multiplex done");
    results();
  end
endmodule

`default_nettype wire

// ==== hw/txbic_defs.svh ====
// Register map, field positions and counts of the transmit backplane pin control.
`ifndef TXBIC_DEFS_SVH
`define TXBIC_DEFS_SVH

`define TXBIC_ADDR_W 4
`define TXBIC_CTRL_OFS 4'h0
`define TXBIC_STAT_OFS 4'h4
`define TXBIC_MFCNT_OFS 4'h8

`define TXBIC_CTRL_RST 8'h00
`define TXBIC_CTRL_WMASK 8'hBF
`define TXBIC_B_FRSIG 4
`define TXBIC_B_INV 3
`define TXBIC_B_MUX 2
`define TXBIC_F_SPD 1:0

`define TXBIC_SPD_BASE 2'h0
`define TXBIC_SPD_2M 2'h1
`define TXBIC_SPD_4M 2'h2
`define TXBIC_SPD_8M 2'h3

`define TXBIC_LAST_SLOT_T1 5'h17
`define TXBIC_LAST_SLOT_HS 5'h1F
`define TXBIC_LAST_BIT_1X 5'h07
`define TXBIC_LAST_BIT_2X 5'h0F
`define TXBIC_LAST_BIT_4X 5'h1F
`define TXBIC_LAST_FRAME 5'h17

`define TXBIC_PIN_SIG 0
`define TXBIC_PIN_FRAC 1
`define TXBIC_PIN_CLK 2
`define TXBIC_PIN_OVH 3

`define TXBIC_MUX_CH0 2'h0
`define TXBIC_MUX_CH1 2'h1

`define TXBIC_OE_ALL 5'h1F
`define TXBIC_OE_ALT 5'h1C
`define TXBIC_OE_HS 5'h1E

`endif

// ==== hw/txbic_pkg.sv ====
// Types shared by the transmit backplane pin control.
`include "txbic_defs.svh"

package txbic_pkg;

  typedef enum logic {
    TXBIC_FBIT,
    TXBIC_SLOT
  } txbic_phase_e;

  typedef struct packed {
    logic [`TXBIC_ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } txbic_req_s;

  typedef struct packed {
    logic frac_sig_en;
    logic inv;
    logic mux_en;
    logic [1:0] speed;
  } txbic_cfg_s;

  typedef struct packed {
    logic valid0;
    logic data0;
    logic valid1;
    logic data1;
    logic sig_bit;
    logic frac_bit;
  } txbic_line_s;

endpackage

// ==== hw/txbic_sync.sv ====
// Two-stage synchroniser for levels entering a clock domain.
`timescale 1ns/1ps
`default_nettype none

module txbic_sync #(
  parameter int W = 1
) (
  // Destination clock
  input wire logic clk_i,
  // Level in and synchronised level out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] hold_r;

  always_ff @(posedge clk_i) begin
    meta_r <= d_i;
    hold_r <= meta_r;
  end

  assign q_o = hold_r;

endmodule

`default_nettype wire

// ==== hw/txbic_top.sv ====
// Transmit backplane interface control: time-slot pin roles, launch edge and demultiplexing.
//
// Summary of operation
// - With fractional/signaling enable 0, the five identifier pins output the channel number.
// - With the enable 1, identifier pin 0 becomes the signaling data input.
// - With the enable 1, identifier pin 1 becomes the fractional data input.
// - With the enable 1, identifier pin 2 outputs the 32 MHz transmit clock.
// - With the enable 1, identifier pin 3 pulses high on each multiframe's first bit.
// - High-speed or multiplexed modes ignore the enable; pin 0 is always signaling input.
// - Clock inversion 0 launches data on rising edges, 1 on falling edges.
// - Clock inversion acts only at base rate, never in high-speed or multiplexed modes.
// - Multiplex enable 1 splits channels 0 and 1 of the four-channel backplane data onto the two line channels.
// - In multiplexed mode the backplane frame is 769 or 1024 link bits per speed field.
// - Outside multiplexed mode the speed field selects 1.544, 2.048, 4.096 or 8.192 Mbit/s.
`timescale 1ns/1ps
`default_nettype none
`include "txbic_defs.svh"

module txbic_top
  import txbic_pkg::*;
#(
  parameter logic [4:0] MF_LAST = `TXBIC_LAST_FRAME
) (
  // System clock, reset and register port
  input wire logic clock_i,
  input wire logic reset_i,
  input wire txbic_req_s req_i,
  output logic [7:0] rdata_o,
  // Backplane link on the backplane transmit clock, plus the separate 32 MHz fast clock
  input wire logic tx_link_clk_i,
  input wire logic tx_frame_sync_i,
  input wire logic tx_ser_i,
  input wire logic fast_clk_32m_i,
  // Time-slot identifier pins
  input wire logic [4:0] timeslot_id_pins_i,
  output logic [4:0] timeslot_id_pins_o,
  output logic [4:0] timeslot_id_pins_oe_o,
  // Line-side channels
  output var txbic_line_s line_o
);

  function automatic logic base_rate(input txbic_cfg_s c);
    return !c.mux_en && (c.speed == `TXBIC_SPD_BASE);
  endfunction

  function automatic logic alt_roles(input txbic_cfg_s c);
    return c.frac_sig_en && base_rate(c);
  endfunction

  // Register file and status on the system clock.
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic mf_seen_r;
  logic mf_seen_nxt;
  logic [7:0] mf_cnt_r;
  logic [7:0] mf_cnt_nxt;
  logic [2:0] back_q;
  txbic_cfg_s cfg_m;

  assign cfg_m = {ctrl_r[`TXBIC_B_FRSIG], ctrl_r[`TXBIC_B_INV], ctrl_r[`TXBIC_B_MUX],
                  ctrl_r[`TXBIC_F_SPD]};

  always_comb begin
    ctrl_nxt = ctrl_r;
    rdata_nxt = 8'h00;
    mf_seen_nxt = back_q[0];
    mf_cnt_nxt = mf_cnt_r + {7'h00, back_q[0] ^ mf_seen_r};
    if (req_i.wr && req_i.addr == `TXBIC_CTRL_OFS) begin
      ctrl_nxt = req_i.wdata & `TXBIC_CTRL_WMASK;
    end
    if (req_i.rd) begin
      if (req_i.addr == `TXBIC_CTRL_OFS) begin
        rdata_nxt = ctrl_r;
      end else if (req_i.addr == `TXBIC_STAT_OFS) begin
        rdata_nxt = {alt_roles(cfg_m), cfg_m.inv && base_rate(cfg_m), base_rate(cfg_m),
                     back_q[1], back_q[2], 3'h0};
      end else if (req_i.addr == `TXBIC_MFCNT_OFS) begin
        rdata_nxt = mf_cnt_r;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ctrl_r <= `TXBIC_CTRL_RST;
      rdata_r <= 8'h00;
      mf_seen_r <= 1'b0;
      mf_cnt_r <= 8'h00;
    end else begin
      ctrl_r <= ctrl_nxt;
      rdata_r <= rdata_nxt;
      mf_seen_r <= mf_seen_nxt;
      mf_cnt_r <= mf_cnt_nxt;
    end
  end

  assign rdata_o = rdata_r;

  // Clock domain crossings.
  // Configuration is quasi-static: software changes it while the link is idle, so a
  // momentary mix of old and new bits for one link cycle is tolerated.
  txbic_cfg_s cfg_l;
  logic link_rst;
  logic [2:0] back_d;

  txbic_sync #(.W(5)) u_cfg_sync (
    .clk_i(tx_link_clk_i),
    .d_i(cfg_m),
    .q_o(cfg_l)
  );

  txbic_sync #(.W(1)) u_rst_sync (
    .clk_i(tx_link_clk_i),
    .d_i(reset_i),
    .q_o(link_rst)
  );

  txbic_sync #(.W(3)) u_back_sync (
    .clk_i(clock_i),
    .d_i(back_d),
    .q_o(back_q)
  );

  // Frame position on the link clock.
  txbic_phase_e phase_r;
  txbic_phase_e phase_nxt;
  logic [4:0] slot_r;
  logic [4:0] slot_nxt;
  logic [4:0] bit_r;
  logic [4:0] bit_nxt;
  logic [4:0] frame_r;
  logic [4:0] frame_nxt;
  logic mf_tog_r;
  logic mf_tog_nxt;
  logic base_l;
  logic has_fbit;
  logic [4:0] last_slot;
  logic [4:0] last_bit;
  logic mf_start;
  logic in_slot;
  logic [4:0] slot_now;
  logic [1:0] ch_now;

  assign base_l = base_rate(cfg_l);
  // The 769-bit multiplexed frame keeps the T1 framing bit; all other fast rates do not.
  assign has_fbit = base_l || (cfg_l.mux_en && cfg_l.speed == `TXBIC_SPD_BASE);
  assign last_slot = has_fbit ? `TXBIC_LAST_SLOT_T1 : `TXBIC_LAST_SLOT_HS;

  always_comb begin
    if (cfg_l.mux_en) begin
      last_bit = `TXBIC_LAST_BIT_4X;
    end else begin
      case (cfg_l.speed)
        `TXBIC_SPD_4M: last_bit = `TXBIC_LAST_BIT_2X;
        `TXBIC_SPD_8M: last_bit = `TXBIC_LAST_BIT_4X;
        default: last_bit = `TXBIC_LAST_BIT_1X;
      endcase
    end
  end

  // Position of the bit arriving on the backplane in this very cycle.
  assign mf_start = tx_frame_sync_i && (frame_r == MF_LAST);
  assign in_slot = tx_frame_sync_i ? !has_fbit : (phase_r == TXBIC_SLOT);
  assign slot_now = tx_frame_sync_i ? 5'h00 : slot_r;
  assign ch_now = tx_frame_sync_i ? `TXBIC_MUX_CH0 : bit_r[1:0];

  always_comb begin
    phase_nxt = phase_r;
    slot_nxt = slot_r;
    bit_nxt = bit_r;
    frame_nxt = frame_r;
    mf_tog_nxt = mf_tog_r ^ mf_start;
    if (tx_frame_sync_i) begin
      frame_nxt = (frame_r == MF_LAST) ? 5'h00 : frame_r + 5'h01;
      phase_nxt = TXBIC_SLOT;
      slot_nxt = 5'h00;
      bit_nxt = has_fbit ? 5'h00 : 5'h01;
    end else begin
      case (phase_r)
        TXBIC_FBIT: begin
          phase_nxt = TXBIC_SLOT;
          slot_nxt = 5'h00;
          bit_nxt = 5'h00;
        end
        default: begin
          if (bit_r == last_bit) begin
            bit_nxt = 5'h00;
            if (slot_r == last_slot) begin
              slot_nxt = 5'h00;
              phase_nxt = has_fbit ? TXBIC_FBIT : TXBIC_SLOT;
            end else begin
              slot_nxt = slot_r + 5'h01;
            end
          end else begin
            bit_nxt = bit_r + 5'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge tx_link_clk_i) begin
    if (link_rst) begin
      phase_r <= TXBIC_SLOT;
      slot_r <= 5'h00;
      bit_r <= 5'h00;
      frame_r <= MF_LAST;
      mf_tog_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      slot_r <= slot_nxt;
      bit_r <= bit_nxt;
      frame_r <= frame_nxt;
      mf_tog_r <= mf_tog_nxt;
    end
  end

  // Pin roles and line data on the link clock.
  logic [4:0] pins_pos_r;
  logic [4:0] pins_nxt;
  logic [4:0] pins_neg_r;
  logic [4:0] oe_r;
  logic [4:0] oe_nxt;
  logic alt_r;
  logic alt_nxt;
  logic inv_r;
  logic inv_nxt;
  logic sig_en_nxt;
  txbic_line_s line_r;
  txbic_line_s line_nxt;
  logic [4:0] pins_launch;

  always_comb begin
    alt_nxt = alt_roles(cfg_l);
    sig_en_nxt = alt_nxt || !base_l;
    inv_nxt = cfg_l.inv && base_l;
    pins_nxt = slot_now;
    if (alt_nxt) begin
      pins_nxt[`TXBIC_PIN_SIG] = 1'b0;
      pins_nxt[`TXBIC_PIN_FRAC] = 1'b0;
      pins_nxt[`TXBIC_PIN_CLK] = 1'b0;
      pins_nxt[`TXBIC_PIN_OVH] = mf_start;
      oe_nxt = `TXBIC_OE_ALT;
    end else if (base_l) begin
      oe_nxt = `TXBIC_OE_ALL;
    end else begin
      oe_nxt = `TXBIC_OE_HS;
    end
    line_nxt = line_r;
    line_nxt.data0 = tx_ser_i;
    line_nxt.data1 = tx_ser_i;
    if (cfg_l.mux_en) begin
      line_nxt.valid0 = in_slot && (ch_now == `TXBIC_MUX_CH0);
      line_nxt.valid1 = in_slot && (ch_now == `TXBIC_MUX_CH1);
    end else begin
      line_nxt.valid0 = 1'b1;
      line_nxt.valid1 = 1'b0;
    end
    if (sig_en_nxt) begin
      line_nxt.sig_bit = timeslot_id_pins_i[`TXBIC_PIN_SIG];
    end
    if (alt_nxt) begin
      line_nxt.frac_bit = timeslot_id_pins_i[`TXBIC_PIN_FRAC];
    end
  end

  always_ff @(posedge tx_link_clk_i) begin
    if (link_rst) begin
      pins_pos_r <= 5'h00;
      oe_r <= `TXBIC_OE_ALL;
      alt_r <= 1'b0;
      inv_r <= 1'b0;
      line_r <= '0;
    end else begin
      pins_pos_r <= pins_nxt;
      oe_r <= oe_nxt;
      alt_r <= alt_nxt;
      inv_r <= inv_nxt;
      line_r <= line_nxt;
    end
  end

  // The falling-edge copy relaunches the rising-edge value half a link cycle later.
  always_ff @(negedge tx_link_clk_i) begin
    if (link_rst) begin
      pins_neg_r <= 5'h00;
    end else begin
      pins_neg_r <= pins_pos_r;
    end
  end

  assign pins_launch = inv_r ? pins_neg_r : pins_pos_r;
  // The fast clock passes a mux steered by a registered select; a switch of roles can
  // leave one short pulse on the pin, which the far side must ignore.
  assign timeslot_id_pins_o = {pins_launch[4:3],
                               alt_r ? fast_clk_32m_i : pins_launch[`TXBIC_PIN_CLK],
                               pins_launch[1:0]};
  assign timeslot_id_pins_oe_o = oe_r;
  assign line_o = line_r;
  assign back_d = {line_r.sig_bit, line_r.frac_bit, mf_tog_r};

  // Checks.
  a_ctrl_store: assert property (@(posedge clock_i) disable iff (reset_i)
    (req_i.wr && req_i.addr == `TXBIC_CTRL_OFS) |=>
      ctrl_r == ($past(req_i.wdata) & `TXBIC_CTRL_WMASK))
    else $error("control register did not take the written value");

  a_pins_normal: assert property (@(posedge tx_link_clk_i) disable iff (link_rst)
    (!alt_nxt && !inv_nxt && base_l) |=>
      (timeslot_id_pins_oe_o == `TXBIC_OE_ALL) && (timeslot_id_pins_o == $past(slot_now)))
    else $error("identifier pins not driving the channel number");

  a_sig_capture: assert property (@(posedge tx_link_clk_i) disable iff (link_rst)
    sig_en_nxt |=> !timeslot_id_pins_oe_o[`TXBIC_PIN_SIG] &&
      line_o.sig_bit == $past(timeslot_id_pins_i[`TXBIC_PIN_SIG]))
    else $error("signaling bit not taken from pin 0");

  a_frac_capture: assert property (@(posedge tx_link_clk_i) disable iff (link_rst)
    alt_nxt |=> !timeslot_id_pins_oe_o[`TXBIC_PIN_FRAC] &&
      line_o.frac_bit == $past(timeslot_id_pins_i[`TXBIC_PIN_FRAC]))
    else $error("fractional bit not taken from pin 1");

  a_fast_clk_out: assert property (@(posedge tx_link_clk_i) disable iff (link_rst)
    alt_r |-> timeslot_id_pins_oe_o[`TXBIC_PIN_CLK] &&
      timeslot_id_pins_o[`TXBIC_PIN_CLK] == fast_clk_32m_i)
    else $error("pin 2 does not carry the fast clock");

  a_ovh_pulse: assert property (@(posedge tx_link_clk_i) disable iff (link_rst)
    (alt_nxt && tx_frame_sync_i && frame_r == MF_LAST && !cfg_l.inv) |=>
      pins_pos_r[`TXBIC_PIN_OVH] ##1 !pins_pos_r[`TXBIC_PIN_OVH] || $past(tx_frame_sync_i))
    else $error("overhead pulse missing at multiframe start");

  a_sig_hs: assert property (@(posedge tx_link_clk_i) disable iff (link_rst)
    !base_l |=> !timeslot_id_pins_oe_o[`TXBIC_PIN_SIG] &&
      timeslot_id_pins_oe_o[`TXBIC_PIN_FRAC] && !alt_r)
    else $error("fast mode pin roles wrong");

  a_fall_launch: assert property (@(negedge tx_link_clk_i) disable iff (link_rst)
    (inv_r && inv_nxt) |=> {timeslot_id_pins_o[4:3], timeslot_id_pins_o[1:0]} ==
      {$past(pins_pos_r[4:3]), $past(pins_pos_r[1:0])})
    else $error("falling-edge launch not applied");

  a_inv_base_only: assert property (@(posedge tx_link_clk_i) disable iff (link_rst)
    !base_l |=> !inv_r)
    else $error("clock inversion active outside base rate");

  a_mux_split: assert property (@(posedge tx_link_clk_i) disable iff (link_rst)
    (cfg_l.mux_en && in_slot && ch_now == `TXBIC_MUX_CH1) |=>
      line_o.valid1 && !line_o.valid0 && line_o.data1 == $past(tx_ser_i))
    else $error("multiplexed bit not routed to line channel 1");

  a_clear_return: assert property (@(posedge tx_link_clk_i) disable iff (link_rst)
    $fell(cfg_l.frac_sig_en) && base_l |=> !alt_r &&
      timeslot_id_pins_oe_o == `TXBIC_OE_ALL)
    else $error("pins did not return to channel output");

  a_slot_wrap: assert property (@(posedge tx_link_clk_i) disable iff (link_rst)
    (base_l && !tx_frame_sync_i && phase_r == TXBIC_SLOT && slot_r == `TXBIC_LAST_SLOT_T1 &&
      bit_r == `TXBIC_LAST_BIT_1X) |=> phase_r == TXBIC_FBIT && slot_r == 5'h00)
    else $error("base-rate frame did not wrap to the framing bit");

endmodule

`default_nettype wire
